// *** rtl/dac_ctrl_pkg.sv ***
package dac_ctrl_pkg;

  // ==========================================================
  // widths
  localparam int CHAN_NUM = 4;
  localparam int SEL_W = 2;
  localparam int DATA_W = 10;
  localparam int PD_W = 2;
  localparam int TEMP_W = 12;
  localparam int BYTE_W = 8;
  localparam int LOW_KEEP_W = 2;
  localparam int WORD_W = 18;

  // ==========================================================
  // update_control_byte field positions
  localparam int CTRL_EA_HI_POS = 7;
  localparam int CTRL_EA_LO_POS = 6;
  localparam int CTRL_LOAD_HI_POS = 5;
  localparam int CTRL_LOAD_LO_POS = 4;
  localparam int CTRL_SEL_HI_POS = 2;
  localparam int CTRL_SEL_LO_POS = 1;
  localparam int CTRL_PD_POS = 0;

  // high_data_byte power-down code sits in its two top bits
  localparam int HIGH_PD_LSB = 6;
  // only the two top bits of low_data_byte carry data
  localparam int LOW_KEEP_LSB = 6;

  // ==========================================================
  // captured command word layout
  localparam int WORD_CTRL_LSB = 10;
  localparam int WORD_HIGH_LSB = 2;
  localparam int WORD_LOW_LSB = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] HIGH_RESET = 8'h00;
  localparam logic [1:0] LOW_RESET = 2'h0;
  localparam logic [11:0] TEMP_RESET = 12'h000;
  localparam logic [9:0] DATA_ZERO = 10'h000;

  // ==========================================================
  // enumerations
  typedef enum logic [1:0] {
    MODE_STORE = 2'h0,
    MODE_LOAD = 2'h1,
    MODE_LOAD_ALL = 2'h2,
    MODE_BROADCAST = 2'h3
  } load_mode_t;

  typedef enum logic [1:0] {
    KIND_CTRL = 2'h0,
    KIND_HIGH = 2'h1,
    KIND_LOW = 2'h2,
    KIND_NONE = 2'h3
  } byte_kind_t;

endpackage

// *** rtl/link_capture.sv ***
`timescale 1ns/1ps
module link_capture (
  input wire logic link_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic [1:0] rx_kind_in,
  input wire logic rx_strobe_in,
  input wire logic ack_fall_in,
  output logic [17:0] word_out,
  output logic toggle_out
);

  // ==========================================================
  // state
  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic [7:0] ctrl;
    logic [7:0] high;
    logic [1:0] low;
    logic high_seen;
    logic low_pend;
    logic [17:0] word;
    logic tog;
  } link_state_t;

  link_state_t st_r;
  link_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_meta = rst_b_in;
    st_nxt.rst_sync = st_r.rst_meta;
    if (!st_r.rst_sync) begin
      st_nxt.ctrl = dac_ctrl_pkg::CTRL_RESET;
      st_nxt.high = dac_ctrl_pkg::HIGH_RESET;
      st_nxt.low = dac_ctrl_pkg::LOW_RESET;
      st_nxt.high_seen = 1'b0;
      st_nxt.low_pend = 1'b0;
      st_nxt.word = {dac_ctrl_pkg::CTRL_RESET, dac_ctrl_pkg::HIGH_RESET,
                     dac_ctrl_pkg::LOW_RESET};
      st_nxt.tog = 1'b0;
    end else begin
      if (ack_fall_in && st_r.low_pend) begin
        st_nxt.word = {st_r.ctrl, st_r.high, st_r.low};
        st_nxt.tog = ~st_r.tog;
        st_nxt.low_pend = 1'b0;
        st_nxt.high_seen = 1'b0;
      end
      if (rx_strobe_in) begin
        case (rx_kind_in)
          dac_ctrl_pkg::KIND_CTRL: begin
            st_nxt.ctrl = rx_byte_in;
            st_nxt.high_seen = 1'b0;
            st_nxt.low_pend = 1'b0;
          end
          dac_ctrl_pkg::KIND_HIGH: begin
            st_nxt.high = rx_byte_in;
            st_nxt.high_seen = 1'b1;
            st_nxt.low_pend = 1'b0;
          end
          dac_ctrl_pkg::KIND_LOW: begin
            st_nxt.low = rx_byte_in[7:dac_ctrl_pkg::LOW_KEEP_LSB];
            st_nxt.low_pend = st_r.high_seen;
          end
          // kind none carries no byte; an ack taken this edge must stand
          default: begin
            st_nxt.low_pend = st_nxt.low_pend;
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_clk_in) begin
    st_r <= st_nxt;
  end

  assign word_out = st_r.word;
  assign toggle_out = st_r.tog;

  // ==========================================================
  // checks
  property p_ctrl_kept;
    @(posedge link_clk_in) disable iff (!st_r.rst_sync)
    rx_strobe_in && (rx_kind_in != dac_ctrl_pkg::KIND_CTRL)
      |=> $stable(st_r.ctrl);
  endproperty
  a_ctrl_kept: assert property (p_ctrl_kept)
    else $error("control byte changed without a control byte");

  property p_word_on_ack;
    @(posedge link_clk_in) disable iff (!st_r.rst_sync)
    ack_fall_in && st_r.low_pend |=> $changed(toggle_out);
  endproperty
  a_word_on_ack: assert property (p_word_on_ack)
    else $error("ack after low byte did not emit an update");

endmodule

// *** rtl/quad_dac_control_byte_decoder.sv ***
// Function
// - extended address must match pins, except broadcast
// - mode 00 stores into selected temp only
// - mode 01 stores temp and output
// - mode 10 loads selected, others from temp
// - broadcast ignores address match and the low select bit
// - broadcast sel_hi 0: outputs from temps
// - broadcast sel_hi 1: all get new data
// - power-down flag makes top bits a code
// - select 00..11 maps channels A..D
// - update happens at ack after low byte
// - sample is high byte plus two bits
// - control byte stays in force between pairs
`timescale 1ns/1ps
module quad_dac_control_byte_decoder #(
  parameter int CHAN_NUM = dac_ctrl_pkg::CHAN_NUM
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic link_clk_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic [1:0] rx_kind_in,
  input wire logic rx_strobe_in,
  input wire logic ack_fall_in,
  input wire logic ext_addr_hi_bit_in,
  input wire logic ext_addr_lo_bit_in,
  output logic [CHAN_NUM-1:0][9:0] chan_code_out,
  output logic [CHAN_NUM-1:0][1:0] chan_pd_out,
  output logic [CHAN_NUM-1:0][11:0] chan_temp_out,
  output logic update_pulse_out
);

  // ==========================================================
  // link side capture
  logic [17:0] word_w;
  logic toggle_w;

  link_capture u_link (
    .link_clk_in(link_clk_in),
    .rst_b_in(rst_b_in),
    .rx_byte_in(rx_byte_in),
    .rx_kind_in(rx_kind_in),
    .rx_strobe_in(rx_strobe_in),
    .ack_fall_in(ack_fall_in),
    .word_out(word_w),
    .toggle_out(toggle_w)
  );

  // ==========================================================
  // state
  typedef struct packed {
    logic tog_s1;
    logic tog_s2;
    logic tog_seen;
    logic [1:0] ea_s1;
    logic [1:0] ea_s2;
    logic [CHAN_NUM-1:0][11:0] temp;
    logic [CHAN_NUM-1:0][11:0] outr;
    logic upd;
  } core_state_t;

  core_state_t st_r;
  core_state_t st_nxt;

  // ==========================================================
  // command decode
  // the word is only read while the toggle edge is fresh; it was
  // written on the same link edge as the toggle, two mclk edges before the toggle reached tog_s2
  logic ev_w;
  logic [7:0] ctrl_w;
  logic [7:0] high_w;
  logic [1:0] low_w;
  logic [1:0] ea_w;
  logic [1:0] sel_w;
  logic sel_hi_w;
  logic pd_w;
  logic match_w;
  logic apply_w;
  logic [11:0] new_w;
  logic [CHAN_NUM-1:0][11:0] new_all_w;
  logic [1:0] oth_sel_w;
  logic [11:0] oth_tmp_w;
  dac_ctrl_pkg::load_mode_t mode_w;

  assign ev_w = st_r.tog_s2 ^ st_r.tog_seen;
  assign ctrl_w = word_w[dac_ctrl_pkg::WORD_CTRL_LSB +: 8];
  assign high_w = word_w[dac_ctrl_pkg::WORD_HIGH_LSB +: 8];
  assign low_w = word_w[dac_ctrl_pkg::WORD_LOW_LSB +: 2];
  assign ea_w = {ctrl_w[dac_ctrl_pkg::CTRL_EA_HI_POS],
                 ctrl_w[dac_ctrl_pkg::CTRL_EA_LO_POS]};
  assign mode_w = dac_ctrl_pkg::load_mode_t'(
    {ctrl_w[dac_ctrl_pkg::CTRL_LOAD_HI_POS],
     ctrl_w[dac_ctrl_pkg::CTRL_LOAD_LO_POS]});
  assign sel_w = {ctrl_w[dac_ctrl_pkg::CTRL_SEL_HI_POS],
                  ctrl_w[dac_ctrl_pkg::CTRL_SEL_LO_POS]};
  assign sel_hi_w = ctrl_w[dac_ctrl_pkg::CTRL_SEL_HI_POS];
  assign pd_w = ctrl_w[dac_ctrl_pkg::CTRL_PD_POS];
  assign match_w = (ea_w == st_r.ea_s2);
  assign apply_w = ev_w &&
    (match_w || (mode_w == dac_ctrl_pkg::MODE_BROADCAST));
  assign new_w = pd_w ?
    {high_w[7:dac_ctrl_pkg::HIGH_PD_LSB], dac_ctrl_pkg::DATA_ZERO} :
    {2'h0, high_w, low_w};
  assign new_all_w = {CHAN_NUM{new_w}};
  assign oth_sel_w = sel_w ^ 2'h1;
  assign oth_tmp_w = st_r.temp[oth_sel_w];

  // ==========================================================
  // per channel update
  logic [CHAN_NUM-1:0][11:0] tmp_nxt_w;
  logic [CHAN_NUM-1:0][11:0] out_nxt_w;

  for (genvar i = 0; i < CHAN_NUM; i++) begin : g_chan
    logic is_sel;
    logic bc;
    logic wr_tmp;
    logic wr_out;
    logic ld_out;
    assign is_sel = (sel_w == 2'(i));
    assign bc = (mode_w == dac_ctrl_pkg::MODE_BROADCAST);
    // temp written in every non-broadcast mode
    assign wr_tmp = apply_w && ((!bc && is_sel) || (bc && sel_hi_w));
    assign wr_out = apply_w &&
      ((((mode_w == dac_ctrl_pkg::MODE_LOAD) ||
         (mode_w == dac_ctrl_pkg::MODE_LOAD_ALL)) && is_sel) ||
       (bc && sel_hi_w));
    assign ld_out = apply_w &&
      (((mode_w == dac_ctrl_pkg::MODE_LOAD_ALL) && !is_sel) ||
       (bc && !sel_hi_w));
    assign tmp_nxt_w[i] = wr_tmp ? new_w : st_r.temp[i];
    assign out_nxt_w[i] = wr_out ? new_w :
                          (ld_out ? st_r.temp[i] : st_r.outr[i]);
  end

  // ==========================================================
  // registers
  always_comb begin
    st_nxt = st_r;
    st_nxt.tog_s1 = toggle_w;
    st_nxt.tog_s2 = st_r.tog_s1;
    st_nxt.tog_seen = st_r.tog_s2;
    st_nxt.ea_s1 = {ext_addr_hi_bit_in, ext_addr_lo_bit_in};
    st_nxt.ea_s2 = st_r.ea_s1;
    st_nxt.temp = tmp_nxt_w;
    st_nxt.outr = out_nxt_w;
    st_nxt.upd = apply_w;
    if (!rst_b_in) begin
      st_nxt.tog_s1 = 1'b0;
      st_nxt.tog_s2 = 1'b0;
      st_nxt.tog_seen = 1'b0;
      st_nxt.ea_s1 = 2'h0;
      st_nxt.ea_s2 = 2'h0;
      st_nxt.temp = {CHAN_NUM{dac_ctrl_pkg::TEMP_RESET}};
      st_nxt.outr = {CHAN_NUM{dac_ctrl_pkg::TEMP_RESET}};
      st_nxt.upd = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    st_r <= st_nxt;
  end

  for (genvar j = 0; j < CHAN_NUM; j++) begin : g_out
    assign chan_code_out[j] = st_r.outr[j][9:0];
    assign chan_pd_out[j] = st_r.outr[j][11:10];
  end
  assign chan_temp_out = st_r.temp;
  assign update_pulse_out = st_r.upd;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  property p_no_match;
    ev_w && !match_w && (mode_w != dac_ctrl_pkg::MODE_BROADCAST)
      |=> $stable(st_r.outr) && $stable(st_r.temp) && !update_pulse_out;
  endproperty
  a_no_match: assert property (p_no_match)
    else $error("mismatched address still updated");

  property p_store_only;
    ev_w && match_w && (mode_w == dac_ctrl_pkg::MODE_STORE)
      |=> $stable(st_r.outr) && (st_r.temp[$past(sel_w)] == $past(new_w));
  endproperty
  a_store_only: assert property (p_store_only)
    else $error("store mode wrong temp or output moved");

  property p_load_one;
    ev_w && match_w && !pd_w && (mode_w == dac_ctrl_pkg::MODE_LOAD)
      |=> chan_code_out[$past(sel_w)] == {$past(high_w), $past(low_w)};
  endproperty
  a_load_one: assert property (p_load_one)
    else $error("load mode did not drive selected output");

  property p_load_all;
    ev_w && match_w && (mode_w == dac_ctrl_pkg::MODE_LOAD_ALL)
      |=> (st_r.outr[$past(oth_sel_w)] == $past(oth_tmp_w)) &&
          (st_r.outr[$past(sel_w)] == $past(new_w));
  endproperty
  a_load_all: assert property (p_load_all)
    else $error("load-all mode outputs wrong");

  property p_bc_temp;
    ev_w && (mode_w == dac_ctrl_pkg::MODE_BROADCAST) && !sel_hi_w
      |=> st_r.outr == $past(st_r.temp);
  endproperty
  a_bc_temp: assert property (p_bc_temp)
    else $error("broadcast did not copy temps to outputs");

  property p_bc_data;
    ev_w && (mode_w == dac_ctrl_pkg::MODE_BROADCAST) && sel_hi_w
      |=> (st_r.outr == $past(new_all_w)) && update_pulse_out;
  endproperty
  a_bc_data: assert property (p_bc_data)
    else $error("broadcast data not on all outputs");

  property p_bc_any_addr;
    ev_w && !match_w && (mode_w == dac_ctrl_pkg::MODE_BROADCAST)
      |=> update_pulse_out;
  endproperty
  a_bc_any_addr: assert property (p_bc_any_addr)
    else $error("broadcast refused on address mismatch");

  property p_pd_code;
    ev_w && match_w && pd_w && (mode_w != dac_ctrl_pkg::MODE_BROADCAST)
      |=> (st_r.temp[$past(sel_w)][11:10] == $past(high_w[7:6])) &&
          (st_r.temp[$past(sel_w)][9:0] == dac_ctrl_pkg::DATA_ZERO);
  endproperty
  a_pd_code: assert property (p_pd_code)
    else $error("power-down code not stored");

  property p_chan_d;
    ev_w && match_w && (mode_w == dac_ctrl_pkg::MODE_STORE) &&
      (sel_w == 2'h3) |=> st_r.temp[3] == $past(new_w);
  endproperty
  a_chan_d: assert property (p_chan_d)
    else $error("select 11 did not reach channel D");

  property p_only_on_event;
    $changed(st_r.outr) |-> $past(apply_w) ##0 update_pulse_out;
  endproperty
  a_only_on_event: assert property (p_only_on_event)
    else $error("output changed without an update event");

  property p_temp_hold;
    !apply_w |=> $stable(st_r.temp) && $stable(st_r.outr);
  endproperty
  a_temp_hold: assert property (p_temp_hold)
    else $error("registers moved without an applied update");

  property p_pulse_single;
    update_pulse_out |=> !update_pulse_out;
  endproperty
  a_pulse_single: assert property (p_pulse_single)
    else $error("update pulse longer than one cycle");

  property p_store_others;
    ev_w && match_w && (mode_w == dac_ctrl_pkg::MODE_STORE)
      |=> st_r.temp[$past(oth_sel_w)] == $past(oth_tmp_w);
  endproperty
  a_store_others: assert property (p_store_others)
    else $error("store mode touched another temp register");

  property p_load_temp;
    ev_w && match_w && (mode_w == dac_ctrl_pkg::MODE_LOAD)
      |=> (st_r.temp[$past(sel_w)] == $past(new_w)) &&
          (st_r.outr[$past(sel_w)] == $past(new_w));
  endproperty
  a_load_temp: assert property (p_load_temp)
    else $error("load mode did not fill temp and output");

  property p_bc_temp_kept;
    ev_w && (mode_w == dac_ctrl_pkg::MODE_BROADCAST) && !sel_hi_w
      |=> $stable(st_r.temp) && update_pulse_out;
  endproperty
  a_bc_temp_kept: assert property (p_bc_temp_kept)
    else $error("broadcast from temps altered a temp register");

  property p_data_no_pd;
    ev_w && match_w && !pd_w && (mode_w == dac_ctrl_pkg::MODE_STORE)
      |=> st_r.temp[$past(sel_w)][11:10] == 2'h0;
  endproperty
  a_data_no_pd: assert property (p_data_no_pd)
    else $error("plain data carried a power-down code");

  property p_chan_a;
    ev_w && match_w && (mode_w == dac_ctrl_pkg::MODE_STORE) &&
      (sel_w == 2'h0) |=> chan_temp_out[0] == $past(new_w);
  endproperty
  a_chan_a: assert property (p_chan_a)
    else $error("select 00 did not reach channel A");

  c_store: cover property (ev_w && match_w &&
    (mode_w == dac_ctrl_pkg::MODE_STORE));
  c_load_all: cover property (ev_w && match_w &&
    (mode_w == dac_ctrl_pkg::MODE_LOAD_ALL));
  c_bc_temp: cover property (ev_w && !sel_hi_w &&
    (mode_w == dac_ctrl_pkg::MODE_BROADCAST));
  c_bc_pd: cover property (ev_w && sel_hi_w && pd_w &&
    (mode_w == dac_ctrl_pkg::MODE_BROADCAST));

endmodule

// *** verif/link_master_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// byte-level model of the bus master behind the byte engine
module link_master_model (
  input wire logic free_run_in,
  output logic link_clk_out,
  output logic [7:0] rx_byte_out,
  output logic [1:0] rx_kind_out,
  output logic rx_strobe_out,
  output logic ack_fall_out
);
  logic run;

  // bus clock stands still between frames, runs free around reset
  initial begin
    run = 1'b0;
    link_clk_out = 1'b0;
    rx_byte_out = 8'hA5;
    rx_kind_out = dac_ctrl_pkg::KIND_NONE;
    rx_strobe_out = 1'b0;
    ack_fall_out = 1'b0;
    #13;
    forever begin
      #40;
      link_clk_out = (run || free_run_in) ? ~link_clk_out : 1'b0;
    end
  end

  // strobe stays up between bytes so no line is set twice in one step
  task automatic put_byte(input logic [7:0] b, input logic [1:0] k);
    rx_byte_out = b;
    rx_kind_out = k;
    rx_strobe_out = 1'b1;
    @(posedge link_clk_out);
    #1;
  endtask

  task automatic send(input logic with_ctrl, input logic [7:0] c,
                      input logic [7:0] h, input logic [7:0] l);
    run = 1'b1;
    @(posedge link_clk_out);
    #1;
    if (with_ctrl) begin
      put_byte(c, dac_ctrl_pkg::KIND_CTRL);
    end
    put_byte(h, dac_ctrl_pkg::KIND_HIGH);
    put_byte(l, dac_ctrl_pkg::KIND_LOW);
    // released byte lines show the inverse so stale data never matches
    rx_strobe_out = 1'b0;
    rx_kind_out = dac_ctrl_pkg::KIND_NONE;
    rx_byte_out = ~l;
    ack_fall_out = 1'b1;
    @(posedge link_clk_out);
    #1;
    ack_fall_out = 1'b0;
    @(posedge link_clk_out);
    #1;
    run = 1'b0;
  endtask
endmodule

// *** verif/test_quad_dac_control_byte_decoder.sv ***
`timescale 1ns/1ps
`define CHECK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
      fail_count++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end \
  end
module test_quad_dac_control_byte_decoder;
  logic mclk, rst_b, free_run, ea_hi, ea_lo, lclk, strobe, ack, pulse;
  logic [7:0] rbyte;
  logic [1:0] kind;
  logic [3:0][9:0] code;
  logic [3:0][1:0] pd;
  logic [3:0][11:0] temp;
  logic [11:0] exp_t [4];
  logic [11:0] exp_o [4];
  logic [7:0] last_ctrl;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int pulse_count = 0;

  quad_dac_control_byte_decoder u_quad_dac_control_byte_decoder (
    .mclk_in(mclk), .rst_b_in(rst_b), .link_clk_in(lclk),
    .rx_byte_in(rbyte), .rx_kind_in(kind), .rx_strobe_in(strobe),
    .ack_fall_in(ack), .ext_addr_hi_bit_in(ea_hi),
    .ext_addr_lo_bit_in(ea_lo), .chan_code_out(code), .chan_pd_out(pd),
    .chan_temp_out(temp), .update_pulse_out(pulse));

  link_master_model u_link_master_model (
    .free_run_in(free_run), .link_clk_out(lclk), .rx_byte_out(rbyte),
    .rx_kind_out(kind), .rx_strobe_out(strobe), .ack_fall_out(ack));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ==========================================================
  // closing report and hang guard
  task automatic give_verdict;
    $display("checked %0d, failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (pulse === 1'b1) begin
      pulse_count++;
    end
    if (cycles == 6000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ==========================================================
  // reference model of temp and output registers
  task automatic predict(input logic [7:0] c, input logic [7:0] h,
                         input logic [7:0] l, output logic hit);
    logic [11:0] v;
    logic [1:0] s;
    s = c[2:1];
    v = c[0] ? {h[7:6], 10'h000} : {2'h0, h, l[7:6]};
    hit = (c[5:4] == 2'h3) || (c[7:6] === {ea_hi, ea_lo});
    if (hit) begin
      case (c[5:4])
        2'h0: exp_t[s] = v;
        2'h1: begin
          exp_t[s] = v;
          exp_o[s] = v;
        end
        2'h2: begin
          exp_t[s] = v;
          for (int i = 0; i < 4; i++) exp_o[i] = exp_t[i];
        end
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (c[2]) exp_t[i] = v;
            exp_o[i] = exp_t[i];
          end
        end
      endcase
    end
  endtask

  task automatic check_all;
    for (int i = 0; i < 4; i++) begin
      `CHECK("code", exp_o[i][9:0], code[i])
      `CHECK("pd", exp_o[i][11:10], pd[i])
      `CHECK("temp", exp_t[i], temp[i])
    end
  endtask

  // one full command through the link, then wait for the update
  task automatic cmd(input logic wc, input logic [7:0] c,
                     input logic [7:0] h, input logic [7:0] l);
    logic hit;
    int base;
    int n;
    if (wc) last_ctrl = c;
    predict(last_ctrl, h, l, hit);
    base = pulse_count;
    u_link_master_model.send(wc, c, h, l);
    n = 0;
    while (pulse_count == base && n < 30) begin
      @(posedge mclk);
      #1;
      n++;
    end
    repeat (3) @(posedge mclk);
    #1;
    `CHECK("pulses", (hit ? 1 : 0), (pulse_count - base))
    check_all();
    $display("test done ctrl %h high %h low %h", last_ctrl, h, l);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    free_run = 1'b1;
    ea_hi = 1'b1;
    ea_lo = 1'b0;
    last_ctrl = dac_ctrl_pkg::CTRL_RESET;
    for (int i = 0; i < 4; i++) begin
      exp_t[i] = dac_ctrl_pkg::TEMP_RESET;
      exp_o[i] = dac_ctrl_pkg::TEMP_RESET;
    end
    // slower link clock sets the reset length
    repeat (12) @(posedge lclk);
    @(posedge mclk);
    #1;
    rst_b = 1'b1;
    repeat (6) @(posedge lclk);
    @(posedge mclk);
    #1;
    free_run = 1'b0;
    check_all();
    $display("test done reset values");
    for (int s = 0; s < 4; s++) begin
      cmd(1'b1, {5'h10, 2'(s), 1'b0}, 8'(8'h37 + s * 16), 8'hFF);
    end
    cmd(1'b1, 8'h92, 8'h5A, 8'h3F);
    cmd(1'b0, 8'h00, 8'hFF, 8'hBF);
    cmd(1'b1, 8'hA4, 8'h81, 8'h40);
    cmd(1'b1, 8'h86, 8'h33, 8'hC0);
    cmd(1'b1, 8'h31, 8'hEE, 8'h00);
    cmd(1'b1, 8'h54, 8'h99, 8'h40);
    cmd(1'b1, 8'h34, 8'hC3, 8'h80);
    cmd(1'b1, 8'h35, 8'hC0, 8'h00);
    cmd(1'b1, 8'h93, 8'h40, 8'h00);
    cmd(1'b0, 8'h00, 8'h80, 8'h40);
    // move the pins so the compare must follow them, not the old level
    ea_hi = 1'b0;
    ea_lo = 1'b1;
    cmd(1'b1, 8'h54, 8'h99, 8'h40);
    give_verdict();
  end
endmodule
